// ==== inc/frp_pkg.sv ====
// Widths, reset values, crossing widths and pointer helpers for the
// FIFO read port. Assumes a write side on clk and a host-driven read clock.
// Overview of operation
// - Output enable switches data drivers, unclocked; registered read select also gates them
// - During resets only output enable controls drivers
// - Almost-empty low below empty offset, else high
// - Almost-full high above full offset, else low
// - Flag timing select caught during full reset
// - Partial reset zeroes pointers and output register
// - Partial reset keeps modes and offsets
// - Clocked read: enabled edge reads word or offset
// - Offset access low outputs offsets on read edges
// - Strobe mode: every strobe edge reads one word
// - Read select gates reads and drivers, clocked
// - Resets ignore read select; output enable decides
// - Rewind zeroes read pointer, forces empty/not-ready
// - Rewind leaves write pointer, modes, offsets alone
// - Rewind goes to marked position when set
// - Serial clock edge shifts bit into offsets
// - Read data bus is 36 bits
// - Mark records current read pointer
// - Offset access selects offset register reads/writes
// - Empty flag shows memory holds no words, or in fall-through mode no word ready
package frp_pkg;
  localparam int DATA_W = 36;
  localparam int AW = 10;
  localparam int PTR_W = AW + 1;
  localparam int DEPTH_N = 1 << AW;
  typedef logic [PTR_W-1:0] frp_ptr_t;
  typedef logic [DATA_W-1:0] frp_data_t;
  typedef logic [AW-1:0] frp_ofs_t;
  typedef enum logic {FRP_OFS_EMPTY, FRP_OFS_FULL} frp_ofs_sel_e;
  localparam frp_ptr_t DEPTH = PTR_W'(DEPTH_N);
  localparam frp_ptr_t PTR_RST = 11'h000;
  localparam frp_ptr_t PTR_ONE = 11'h001;
  localparam frp_data_t DATA_RST = 36'h0;
  localparam frp_ofs_t EMPTY_OFS_RST = 10'h07f;
  localparam frp_ofs_t FULL_OFS_RST = 10'h07f;
  localparam logic [1:0] FLAG_HI = 2'h3;
  localparam logic [1:0] FLAG_LO = 2'h0;
  localparam int PIN_SYNC_W = 8;
  localparam int RD_SYNC_W = 5 + PTR_W + 2 * AW;

  function automatic frp_ptr_t frp_bin2gray(input frp_ptr_t b);
    return b ^ (b >> 1);
  endfunction : frp_bin2gray

  function automatic frp_ptr_t frp_gray2bin(input frp_ptr_t g);
    frp_ptr_t b;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--)
      b[i] = b[i+1] ^ g[i];
    return b;
  endfunction : frp_gray2bin
endpackage : frp_pkg

// ==== inc/frp_cross_if.sv ====
// Carrier for one synchroniser: raw word in, resynchronised word out.
// Assumes the source side drives d and the synchroniser drives q.
`timescale 1ns/100ps
`default_nettype none
interface frp_cross_if #(parameter int W = 1);
  logic [W-1:0] d;
  logic [W-1:0] q;
  modport src (output d, input q);
  modport dst (input d, output q);
endinterface : frp_cross_if
`default_nettype wire

// ==== verilog/frp_sync.sv ====
// Two-flop synchroniser for levels and gray-coded words.
// Assumes multi-bit inputs change by at most one bit at a time.
`timescale 1ns/100ps
`default_nettype none
module frp_sync #(parameter int W = 1)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  frp_cross_if.dst x
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } frp_sync_s;

  frp_sync_s sync_reg;
  frp_sync_s sync_next;

  // First stage feeds only the second stage
  always_comb
  begin
    sync_next = sync_reg;
    sync_next.s1 = x.d;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sync_reg <= '0;
    else if (en)
      sync_reg <= sync_next;
  end

  assign x.q = sync_reg.s2;
endmodule : frp_sync
`default_nettype wire

// ==== verilog/frp_read_port.sv ====
// Read side of a dual-clock FIFO: memory, pointers, flags, offsets.
// Assumes write requests come from logic on clk and the host drives
// rclk with its read-side controls synchronous to it.
`timescale 1ns/100ps
`default_nettype none
module frp_read_port
  import frp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic full_reset_n,
  input wire logic partial_reset_n,
  input wire logic flag_timing_select,
  input wire logic first_word_fallthrough,
  input wire logic read_clocked_select,
  input wire logic offset_access_n,
  input wire logic offset_shift_enable_n,
  input wire logic offset_shift_clk,
  input wire logic wr_en,
  input wire logic [DATA_W-1:0] wr_data,
  output logic wr_ready,
  input wire logic rclk,
  input wire logic read_enable_n,
  input wire logic read_select_n,
  input wire logic rewind_n,
  input wire logic mark,
  input wire logic output_enable_n,
  output logic [DATA_W-1:0] read_data_out,
  output logic read_data_oe,
  output logic [1:2] empty_flag_n,
  output logic [1:2] almost_empty_flag_n,
  output logic [1:2] almost_full_flag_n
);
  typedef struct packed {
    frp_ptr_t wptr;
    frp_ptr_t wgray;
    frp_ofs_t empty_ofs;
    frp_ofs_t full_ofs;
    frp_ofs_sel_e pw_sel;
    logic sclk_d;
    logic cfg_pfm;
    logic cfg_clocked;
    logic cfg_first_word_fallthrough;
    logic cfg_serial;
    logic [1:0] af;
    logic [1:0] ae;
    logic wr_ready;
  } frp_sys_s;

  typedef struct packed {
    frp_ptr_t rptr;
    frp_ptr_t rgray;
    frp_ptr_t mark_ptr;
    logic mark_set;
    frp_data_t dout;
    logic dvalid;
    frp_ofs_sel_e ofs_sel;
    logic [1:0] ef;
    logic [1:0] ae;
    logic sel;
    logic in_rst;
  } frp_rd_s;

  frp_sys_s sys_reg;
  frp_sys_s sys_next;
  frp_rd_s rd_reg;
  frp_rd_s rd_next;

  // Write-once, read-later storage; each address has a single writer
  frp_data_t mem [0:DEPTH_N-1];

  logic fr_s;
  logic pr_s;
  logic pfm_s;
  logic first_word_fallthrough_s;
  logic clk_sel_s;
  logic ld_s;
  logic sen_s;
  logic sclk_s;
  logic rfr_s;
  logic rpr_s;
  logic rce_s;
  logic rsync_s;
  logic rfwft_s;
  frp_ptr_t wgray_s;
  frp_ofs_t eofs_s;
  frp_ofs_t fofs_s;

  frp_ptr_t rptr_c;
  frp_ptr_t words_c;
  frp_ptr_t words_cn;
  frp_ptr_t free_c;
  logic sclk_rise;
  logic do_write;

  frp_ptr_t wptr_r;
  frp_ptr_t words_r;
  frp_ptr_t words_rn;
  logic rd_go;
  logic rewound;

  frp_cross_if #(.W(PIN_SYNC_W)) pin_x ();
  frp_cross_if #(.W(RD_SYNC_W)) rd_x ();
  frp_cross_if #(.W(PTR_W)) rp_x ();

  assign pin_x.d = {full_reset_n, partial_reset_n, flag_timing_select,
                    first_word_fallthrough, read_clocked_select,
                    offset_access_n, offset_shift_enable_n,
                    offset_shift_clk};
  assign {fr_s, pr_s, pfm_s, first_word_fallthrough_s, clk_sel_s, ld_s, sen_s, sclk_s} =
    pin_x.q;

  // Offsets and modes are quasi-static; the pointer travels gray coded
  assign rd_x.d = {full_reset_n, partial_reset_n, ce, sys_reg.cfg_clocked,
                   sys_reg.cfg_first_word_fallthrough, sys_reg.wgray, sys_reg.empty_ofs,
                   sys_reg.full_ofs};
  assign {rfr_s, rpr_s, rce_s, rsync_s, rfwft_s, wgray_s, eofs_s, fofs_s} =
    rd_x.q;

  assign rp_x.d = rd_reg.rgray;

  frp_sync #(.W(PIN_SYNC_W)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .en(ce),
    .x(pin_x)
  );

  // Runs ungated: the clock enable itself arrives through it
  frp_sync #(.W(RD_SYNC_W)) u_rd_sync (
    .clk(rclk),
    .rst_n(rst_n),
    .en(1'b1),
    .x(rd_x)
  );

  frp_sync #(.W(PTR_W)) u_rp_sync (
    .clk(clk),
    .rst_n(rst_n),
    .en(ce),
    .x(rp_x)
  );

  // System clock side: write pointer, offsets, straps, full-side flags
  always_comb
  begin
    sys_next = sys_reg;
    rptr_c = frp_gray2bin(rp_x.q);
    words_c = sys_reg.wptr - rptr_c;
    free_c = DEPTH - words_c;
    sclk_rise = sclk_s & ~sys_reg.sclk_d;
    do_write = 1'b0;
    sys_next.sclk_d = sclk_s;
    if (!fr_s)
    begin
      sys_next.cfg_pfm = pfm_s;
      sys_next.cfg_clocked = clk_sel_s;
      // Strobe reads force standard mode
      sys_next.cfg_first_word_fallthrough = first_word_fallthrough_s & clk_sel_s;
      sys_next.cfg_serial = ld_s;
      sys_next.empty_ofs = EMPTY_OFS_RST;
      sys_next.full_ofs = FULL_OFS_RST;
      sys_next.wptr = PTR_RST;
      sys_next.pw_sel = FRP_OFS_EMPTY;
    end
    else if (!pr_s)
    begin
      // Modes and offsets deliberately left as they are
      sys_next.wptr = PTR_RST;
      sys_next.pw_sel = FRP_OFS_EMPTY;
    end
    else
    begin
      if (sys_reg.cfg_serial && !sen_s && sclk_rise)
      begin
        // Serial bit shares the fall-through strap pin
        {sys_next.full_ofs, sys_next.empty_ofs} =
          {sys_reg.full_ofs[AW-2:0], sys_reg.empty_ofs, first_word_fallthrough_s};
      end
      if (wr_en && !ld_s)
      begin
        if (!sys_reg.cfg_serial)
        begin
          if (sys_reg.pw_sel == FRP_OFS_EMPTY)
          begin
            sys_next.empty_ofs = wr_data[AW-1:0];
            sys_next.pw_sel = FRP_OFS_FULL;
          end
          else
          begin
            sys_next.full_ofs = wr_data[AW-1:0];
            sys_next.pw_sel = FRP_OFS_EMPTY;
          end
        end
      end
      else if (wr_en && words_c != DEPTH)
      begin
        do_write = 1'b1;
        sys_next.wptr = sys_reg.wptr + PTR_ONE;
      end
    end
    sys_next.wgray = frp_bin2gray(sys_next.wptr);
    words_cn = sys_next.wptr - rptr_c;
    // Read side seen late, so free space is never overstated
    sys_next.af = (free_c > {1'b0, sys_reg.full_ofs}) ?
                  FLAG_HI : FLAG_LO;
    sys_next.ae = (words_c >= {1'b0, sys_reg.empty_ofs}) ?
                  FLAG_HI : FLAG_LO;
    sys_next.wr_ready = fr_s & pr_s & (words_cn != DEPTH);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sys_reg <= '0;
    else if (ce)
      sys_reg <= sys_next;
  end

  always_ff @(posedge clk)
  begin
    if (ce && do_write)
      mem[sys_reg.wptr[AW-1:0]] <= wr_data;
  end

  // Read clock side: read pointer, mark, output register, empty flags
  always_comb
  begin
    rd_next = rd_reg;
    rewound = 1'b0;
    wptr_r = frp_gray2bin(wgray_s);
    words_r = wptr_r - rd_reg.rptr;
    // Strobe mode reads on every edge; read enable is held low there
    rd_go = (rsync_s ? !read_enable_n : 1'b1) & !read_select_n;
    rd_next.in_rst = !rfr_s | !rpr_s;
    rd_next.sel = read_select_n;
    if (!rfr_s || !rpr_s)
    begin
      rd_next.rptr = PTR_RST;
      rd_next.dout = DATA_RST;
      rd_next.dvalid = 1'b0;
      rd_next.mark_set = 1'b0;
      rd_next.ofs_sel = FRP_OFS_EMPTY;
    end
    else if (!rewind_n)
    begin
      // Write pointer, modes and offsets live elsewhere and stay put
      rd_next.rptr = rd_reg.mark_set ? rd_reg.mark_ptr : PTR_RST;
      rd_next.dvalid = 1'b0;
      rewound = 1'b1;
    end
    else
    begin
      if (mark)
      begin
        rd_next.mark_ptr = rd_reg.rptr;
        rd_next.mark_set = 1'b1;
      end
      if (rd_go && !offset_access_n)
      begin
        if (rd_reg.ofs_sel == FRP_OFS_EMPTY)
        begin
          rd_next.dout = {{(DATA_W-AW){1'b0}}, eofs_s};
          rd_next.ofs_sel = FRP_OFS_FULL;
        end
        else
        begin
          rd_next.dout = {{(DATA_W-AW){1'b0}}, fofs_s};
          rd_next.ofs_sel = FRP_OFS_EMPTY;
        end
      end
      else if (rfwft_s)
      begin
        if ((!rd_reg.dvalid || rd_go) && words_r != PTR_RST)
        begin
          rd_next.dout = mem[rd_reg.rptr[AW-1:0]];
          rd_next.rptr = rd_reg.rptr + PTR_ONE;
          rd_next.dvalid = 1'b1;
        end
        else if (rd_go)
        begin
          rd_next.dvalid = 1'b0;
        end
      end
      else if (rd_go && words_r != PTR_RST)
      begin
        rd_next.dout = mem[rd_reg.rptr[AW-1:0]];
        rd_next.rptr = rd_reg.rptr + PTR_ONE;
      end
    end
    words_rn = wptr_r - rd_next.rptr;
    if (rewound)
      rd_next.ef = rfwft_s ? FLAG_HI : FLAG_LO;
    else if (rfwft_s)
      rd_next.ef = rd_next.dvalid ? FLAG_LO : FLAG_HI;
    else
      rd_next.ef = (words_rn != PTR_RST) ? FLAG_HI : FLAG_LO;
    rd_next.ae = (words_rn >= {1'b0, eofs_s}) ? FLAG_HI : FLAG_LO;
    rd_next.rgray = frp_bin2gray(rd_next.rptr);
  end

  // Shares the async reset; release may land mid-cycle of rclk
  always_ff @(posedge rclk or negedge rst_n)
  begin
    if (!rst_n)
      rd_reg <= '0;
    else if (rce_s)
      rd_reg <= rd_next;
  end

  assign read_data_out = rd_reg.dout;
  // Must act without a clock edge, hence gates after the flops
  assign read_data_oe = !output_enable_n &
                        (rd_reg.in_rst | !rd_reg.sel);
  assign empty_flag_n = rd_reg.ef;
  assign almost_empty_flag_n = sys_reg.cfg_pfm ? rd_reg.ae : sys_reg.ae;
  assign almost_full_flag_n = sys_reg.af;
  assign wr_ready = sys_reg.wr_ready;
endmodule : frp_read_port
`default_nettype wire

// ==== bench/frp_read_port_sva.sv ====
// Port checks for the FIFO read port.
// Assumes standard mode, read enable low for strobe reads, free rclk.
`timescale 1ns/100ps
`default_nettype none
module frp_read_port_sva
  import frp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rclk,
  input wire logic full_reset_n,
  input wire logic partial_reset_n,
  input wire logic output_enable_n,
  input wire logic read_enable_n,
  input wire logic read_select_n,
  input wire logic rewind_n,
  input wire logic wr_ready,
  input wire logic [DATA_W-1:0] read_data_out,
  input wire logic read_data_oe,
  input wire logic [1:2] empty_flag_n,
  input wire logic [1:2] almost_empty_flag_n,
  input wire logic [1:2] almost_full_flag_n
);
  property p_oe_off;
    @(posedge clk) disable iff (!rst_n) output_enable_n |-> !read_data_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("drive while off");
  // Five edges cover the two-flop reset sync
  property p_rst_oe;
    @(posedge rclk) disable iff (!rst_n)
      !full_reset_n [*5] |-> read_data_oe == !output_enable_n;
  endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("oe in reset");
  property p_prst_data;
    @(posedge rclk) disable iff (!rst_n)
      !partial_reset_n [*5] |-> read_data_out == '0;
  endproperty
  a_prst_data: assert property (p_prst_data) else $error("data kept");
  property p_hold;
    @(posedge rclk) disable iff (!rst_n)
      read_select_n && full_reset_n && partial_reset_n |=> $stable(read_data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("read unselected");
  property p_rd_only;
    @(posedge rclk) disable iff (!rst_n)
      (full_reset_n && partial_reset_n) [*4] ##0 !$stable(read_data_out)
      |-> $past(!read_enable_n && !read_select_n);
  endproperty
  a_rd_only: assert property (p_rd_only) else $error("stray read");
  property p_rew;
    @(posedge rclk) disable iff (!rst_n)
      !rewind_n && full_reset_n |=> empty_flag_n == FLAG_LO;
  endproperty
  a_rew: assert property (p_rew) else $error("rewind flag");
  property p_pair;
    @(posedge clk) disable iff (!rst_n)
      almost_empty_flag_n[1] == almost_empty_flag_n[2]
      && almost_full_flag_n[1] == almost_full_flag_n[2];
  endproperty
  a_pair: assert property (p_pair) else $error("copies differ");
  property p_ae_rst;
    @(posedge clk) disable iff (!rst_n)
      !full_reset_n [*8] |-> almost_empty_flag_n == FLAG_LO;
  endproperty
  a_ae_rst: assert property (p_ae_rst) else $error("ae in reset");
  property p_wr_rst;
    @(posedge clk) disable iff (!rst_n)
      (!partial_reset_n || !full_reset_n) [*5] |-> !wr_ready;
  endproperty
  a_wr_rst: assert property (p_wr_rst) else $error("ready in reset");
  c_rew: cover property (@(posedge rclk) !rewind_n);
  c_af: cover property (@(posedge clk) almost_full_flag_n == FLAG_LO);
  c_sel: cover property (@(posedge rclk) read_select_n && !read_enable_n);
endmodule : frp_read_port_sva
bind frp_read_port frp_read_port_sva u_sva
(
  .clk, .rst_n, .rclk, .full_reset_n, .partial_reset_n,
  .output_enable_n, .read_enable_n, .read_select_n, .rewind_n,
  .wr_ready, .read_data_out, .read_data_oe, .empty_flag_n,
  .almost_empty_flag_n, .almost_full_flag_n
);
`default_nettype wire

// ==== bench/frp_host_model.sv ====
// Host model: read clock or strobe, and the read enable.
// Assumes the bench calls rd away from rclk edges.
`timescale 1ns/100ps
`default_nettype none
module frp_host_model
(
  output logic rclk,
  output logic read_enable_n
);
  initial
  begin
    rclk = 1'b0;
    read_enable_n = 1'b1;
  end
  // Free-running, resets need read edges
  always #62.5 rclk = ~rclk;
  task automatic rd(input int n);
    @(posedge rclk) read_enable_n <= 1'b0;
    repeat (n) @(posedge rclk);
    read_enable_n <= 1'b1;
  endtask : rd
  // Strobe mode reads on every edge; read enable just stays low
  task automatic hold_enable();
    @(posedge rclk) read_enable_n <= 1'b0;
  endtask : hold_enable
endmodule : frp_host_model
`default_nettype wire

// ==== bench/frp_read_port_test.sv ====
// Self-checking bench for the FIFO read port, clocked and strobe reads.
// Assumes frp_host_model makes rclk and read enable.
`timescale 1ns/100ps
`default_nettype none
module frp_read_port_test
  import frp_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, full_reset_n = 1'b0;
  logic partial_reset_n = 1'b1, ce = 1'b1, flag_timing_select = 1'b1;
  logic first_word_fallthrough = 1'b0, read_clocked_select = 1'b1;
  logic offset_access_n = 1'b0, offset_shift_enable_n = 1'b1;
  logic offset_shift_clk = 1'b0, wr_en = 1'b0, read_select_n = 1'b0;
  logic rewind_n = 1'b1, mark = 1'b0, output_enable_n = 1'b0;
  logic [DATA_W-1:0] wr_data = '0;
  // Serial load: full offset 5, empty offset 3, full offset first
  logic [19:0] ser_ofs = {10'h005, 10'h003};
  logic [DATA_W-1:0] read_data_out;
  logic wr_ready, rclk, read_enable_n, read_data_oe;
  logic [1:2] empty_flag_n, almost_empty_flag_n, almost_full_flag_n;
  int fails = 0, comparisons = 0, cyc = 0, wc = 0;
  typedef struct {int n; logic [1:2] ae; logic [1:2] af;} frp_row_s;
  // Offsets are programmed to 4 and 2
  frp_row_s rows [4] = '{'{3, FLAG_LO, FLAG_HI}, '{4, FLAG_HI, FLAG_HI},
    '{1021, FLAG_HI, FLAG_HI}, '{1022, FLAG_HI, FLAG_LO}};
  frp_read_port DUT (.clk, .rst_n, .ce, .full_reset_n, .partial_reset_n,
    .flag_timing_select, .first_word_fallthrough, .read_clocked_select,
    .offset_access_n, .offset_shift_enable_n, .offset_shift_clk, .wr_en,
    .wr_data, .wr_ready, .rclk, .read_enable_n, .read_select_n, .rewind_n,
    .mark, .output_enable_n, .read_data_out, .read_data_oe, .empty_flag_n,
    .almost_empty_flag_n, .almost_full_flag_n);
  frp_host_model u_host (.rclk, .read_enable_n);
  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    // Free-running serial clock; offsets move only while enabled
    if (cyc % 16 == 0)
      offset_shift_clk <= ~offset_shift_clk;
    if (cyc == 12000)
    begin
      fails++;
      stop_test();
    end
  end
  task automatic chk(input frp_data_t seen, input frp_data_t exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic chf(input logic [1:2] s, input logic [1:2] e);
    chk(DATA_W'(s), DATA_W'(e));
  endtask : chf
  task automatic wr(input frp_data_t d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_data <= d;
    do @(posedge clk); while (wr_ready !== 1'b1);
    wr_en <= 1'b0;
  endtask : wr
  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    full_reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chf(empty_flag_n, FLAG_LO);
    chf(almost_empty_flag_n, FLAG_LO);
    chf(almost_full_flag_n, FLAG_HI);
    $display("test reset done");
    wr(36'h4);
    wr(36'h2);
    u_host.rd(1);
    #1;
    chk(read_data_out, 36'h4);
    u_host.rd(1);
    #1;
    chk(read_data_out, 36'h2);
    @(posedge clk) offset_access_n <= 1'b1;
    repeat (4) @(posedge clk);
    $display("test offsets done");
    foreach (rows[i])
    begin
      while (wc < rows[i].n)
      begin
        wr(DATA_W'(wc));
        wc++;
      end
      repeat (12) @(posedge clk);
      #1;
      chf(almost_empty_flag_n, rows[i].ae);
      chf(almost_full_flag_n, rows[i].af);
    end
    $display("test flags done");
    u_host.rd(2);
    #1;
    chk(read_data_out, 36'h1);
    @(posedge rclk) mark <= 1'b1;
    @(posedge rclk) mark <= 1'b0;
    u_host.rd(3);
    #1;
    chk(read_data_out, 36'h4);
    @(posedge rclk) rewind_n <= 1'b0;
    @(posedge rclk) rewind_n <= 1'b1;
    #1;
    chf(empty_flag_n, FLAG_LO);
    @(posedge rclk) #1;
    chf(empty_flag_n, FLAG_HI);
    u_host.rd(1);
    #1;
    chk(read_data_out, 36'h2);
    $display("test rewind done");
    @(posedge rclk) read_select_n <= 1'b1;
    u_host.rd(1);
    #1;
    chk(read_data_out, 36'h2);
    chk(DATA_W'(read_data_oe), 36'h0);
    @(posedge clk) read_select_n <= 1'b0;
    output_enable_n <= 1'b1;
    @(posedge clk) #1;
    chk(DATA_W'(read_data_oe), 36'h0);
    @(posedge clk) output_enable_n <= 1'b0;
    @(posedge clk) #1;
    chk(DATA_W'(read_data_oe), 36'h1);
    $display("test select done");
    @(posedge clk) partial_reset_n <= 1'b0;
    @(posedge rclk) read_select_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk(read_data_out, 36'h0);
    chf(empty_flag_n, FLAG_LO);
    chk(DATA_W'(read_data_oe), 36'h1);
    chk(DATA_W'(wr_ready), 36'h0);
    @(posedge rclk) read_select_n <= 1'b0;
    @(posedge clk) partial_reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    chf(almost_empty_flag_n, FLAG_LO);
    repeat (4) wr(36'h9);
    repeat (12) @(posedge clk);
    chf(almost_empty_flag_n, FLAG_HI);
    $display("test partial reset done");
    // Second full reset: serial method, unclocked flag timing
    @(posedge clk) full_reset_n <= 1'b0;
    flag_timing_select <= 1'b0;
    offset_access_n <= 1'b1;
    repeat (8) @(posedge clk);
    full_reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    for (int i = 19; i >= 0; i--)
    begin
      @(negedge offset_shift_clk);
      offset_shift_enable_n <= 1'b0;
      first_word_fallthrough <= ser_ofs[i];
    end
    @(negedge offset_shift_clk);
    offset_shift_enable_n <= 1'b1;
    first_word_fallthrough <= 1'b0;
    offset_access_n <= 1'b0;
    repeat (4) @(posedge clk);
    u_host.rd(1);
    #1;
    chk(read_data_out, 36'h3);
    u_host.rd(1);
    #1;
    chk(read_data_out, 36'h5);
    @(posedge clk) offset_access_n <= 1'b1;
    repeat (4) @(posedge clk);
    wr(36'h11);
    wr(36'h12);
    repeat (12) @(posedge clk);
    #1;
    chf(almost_empty_flag_n, FLAG_LO);
    wr(36'h13);
    // Clocked flag timing would still wait for the read side here
    @(posedge clk) #1;
    chf(almost_empty_flag_n, FLAG_HI);
    $display("test serial offsets done");
    @(posedge clk) ce <= 1'b0;
    repeat (8) @(posedge clk);
    u_host.rd(1);
    #1;
    chk(read_data_out, 36'h5);
    @(posedge clk) ce <= 1'b1;
    repeat (8) @(posedge clk);
    u_host.rd(1);
    #1;
    chk(read_data_out, 36'h11);
    $display("test clock enable done");
    // Deselect before read enable drops, so no clocked read slips in
    @(posedge rclk) read_select_n <= 1'b1;
    u_host.hold_enable();
    @(posedge clk) full_reset_n <= 1'b0;
    read_clocked_select <= 1'b0;
    repeat (8) @(posedge clk);
    full_reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    wr(36'h21);
    wr(36'h22);
    repeat (12) @(posedge clk);
    @(posedge rclk) read_select_n <= 1'b0;
    @(posedge rclk) read_select_n <= 1'b1;
    #1;
    chk(read_data_out, 36'h21);
    chf(empty_flag_n, FLAG_HI);
    $display("test strobe read done");
    stop_test();
  end
endmodule : frp_read_port_test
`default_nettype wire
